// File: design/dcr_cfg.svh
`ifndef DCR_CFG_SVH
`define DCR_CFG_SVH
// Contract
// - Three routed interrupts, one channel each
// - Routed channel masked from master interrupt
// - Flag clear affects only master-routed channels
// - Error flag stays until software clears
// - Disabled channel ignores every request
// - Completion clears the channel enable
// - Module disabled means no operation
// - Burst-only channel ignores single requests
// - Alternate attribute selects alternate structure
// - Priority attribute puts channel high class
// - Request mask blocks hardware requests only
// - Attributes set, cleared, read independently
// - Per-channel peripheral source selection
// - Software trigger of routed channel interrupt
// - Master status: one bit per channel
// - Software request starts a channel transfer
// - Mode reads idle after completion

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define DCR_ADDR_W 8
`define DCR_OFF_MOD_CTRL 8'h00
`define DCR_OFF_EN_SET 8'h04
`define DCR_OFF_EN_CLR 8'h08
`define DCR_OFF_CH_SEL 8'h0c
`define DCR_OFF_ATTR_SET 8'h10
`define DCR_OFF_ATTR_CLR 8'h14
`define DCR_OFF_SRC_MAP 8'h18
`define DCR_OFF_MODE 8'h1c
`define DCR_OFF_SW_REQ 8'h20
`define DCR_OFF_DONE_STAT 8'h24
`define DCR_OFF_DONE_CLR 8'h28
`define DCR_OFF_ROUTE 8'h2c
`define DCR_OFF_INT_TRIG 8'h30
`define DCR_OFF_ERR_STAT 8'h34
`define DCR_OFF_EVT_STAT 8'h38
`define DCR_OFF_EVT_MASK 8'h3c

// ----------------------------------------------------------------
// Field positions and values
// ----------------------------------------------------------------
`define DCR_MOD_EN_BIT 0
`define DCR_ATTR_BURST 0
`define DCR_ATTR_ALT 1
`define DCR_ATTR_HI 2
`define DCR_ATTR_MASK 3
`define DCR_NUM_ROUTE 3
`define DCR_RT_W 8
`define DCR_RT_ASG 6
`define DCR_RT_EN 7
`define DCR_ERR_BIT 0
`define DCR_EVT_DONE 0
`define DCR_EVT_ERR 1
`define DCR_EVT_W 2
`define DCR_MODE_W 3
`define DCR_MODE_IDLE 3'h0

`endif

// File: design/dcr_pkg.sv
package dcr_pkg;
  typedef enum logic {ST_IDLE, ST_BUSY} dcr_state_e;
  typedef logic [3:0] dcr_attr_t;
endpackage : dcr_pkg

// File: design/dcr_prio_arb.sv
`timescale 1ns/1ps
module dcr_prio_arb #(
  parameter int N = 32,
  parameter int IW = 5
) (
  // Requests
  input wire logic [N-1:0] req_i,
  input wire logic [N-1:0] hi_i,
  // Grant
  output logic gnt_valid_o,
  output logic [IW-1:0] gnt_idx_o
);
  function automatic logic [IW-1:0] first_set(input logic [N-1:0] v);
    logic [IW-1:0] idx;
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = IW'(i);
      end
    end
    return idx;
  endfunction : first_set

  logic [N-1:0] hi_req;

  // High class wins outright, lowest index within a class
  assign hi_req = req_i & hi_i;
  assign gnt_idx_o = (|hi_req) ? first_set(hi_req) : first_set(req_i);
  assign gnt_valid_o = |req_i;
endmodule : dcr_prio_arb

// File: design/dcr_mode_mem.sv
`timescale 1ns/1ps
`include "dcr_cfg.svh"
module dcr_mode_mem #(
  parameter int DEPTH = 32,
  parameter int AW = 5,
  parameter int DW = 3
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Write port
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  // Read port
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);
  logic [DW-1:0] mem_ff [DEPTH];
  logic [DW-1:0] rdata_ff;

  // Reset loads idle so a fresh channel never reads as running
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= DW'(`DCR_MODE_IDLE);
      end
    end else if (we_i) begin
      mem_ff[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= mem_ff[raddr_i];
    end
  end

  assign rdata_o = rdata_ff;
endmodule : dcr_mode_mem

// File: design/dcr_ctrl.sv
`timescale 1ns/1ps
`include "dcr_cfg.svh"
module dcr_ctrl #(
  parameter int NUM_CH = 32,
  parameter int CH_W = 5,
  parameter int NUM_SRC = 8,
  parameter int SRC_W = 3
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [`DCR_ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Peripheral request lines
  input wire logic [NUM_SRC-1:0] periph_breq_i,
  input wire logic [NUM_SRC-1:0] periph_sreq_i,
  // Data path handshake
  output logic xfer_start_o,
  output logic [CH_W-1:0] xfer_ch_o,
  output dcr_pkg::dcr_attr_t xfer_attr_o,
  input wire logic xfer_done_i,
  input wire logic xfer_err_i,
  // Interrupts
  output logic master_done_irq_o,
  output logic routed_irq_one_o,
  output logic routed_irq_two_o,
  output logic routed_irq_three_o,
  output logic fault_irq_o,
  output logic irq_o
);
  import dcr_pkg::*;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_ff;
  logic rst_sync_ff;
  logic rst_n;

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  assign rst_n = rst_sync_ff;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [`DCR_ADDR_W-1:0] a,
                               input logic [`DCR_ADDR_W-1:0] o);
    return a == o;
  endfunction : hit

  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  wire acc = psel_i & penable_i;
  wire wr_go = acc & pready_ff & pwrite_i;
  wire rd_go = acc & pready_ff & ~pwrite_i;
  wire rd_load = acc & ~pready_ff & ~pwrite_i;
  wire wr_mod = wr_go & hit(paddr_i, `DCR_OFF_MOD_CTRL);
  wire wr_en_set = wr_go & hit(paddr_i, `DCR_OFF_EN_SET);
  wire wr_en_clr = wr_go & hit(paddr_i, `DCR_OFF_EN_CLR);
  wire wr_ch_sel = wr_go & hit(paddr_i, `DCR_OFF_CH_SEL);
  wire wr_attr_set = wr_go & hit(paddr_i, `DCR_OFF_ATTR_SET);
  wire wr_attr_clr = wr_go & hit(paddr_i, `DCR_OFF_ATTR_CLR);
  wire wr_src = wr_go & hit(paddr_i, `DCR_OFF_SRC_MAP);
  wire wr_mode = wr_go & hit(paddr_i, `DCR_OFF_MODE);
  wire wr_sw_req = wr_go & hit(paddr_i, `DCR_OFF_SW_REQ);
  wire wr_done_clr = wr_go & hit(paddr_i, `DCR_OFF_DONE_CLR);
  wire wr_route = wr_go & hit(paddr_i, `DCR_OFF_ROUTE);
  wire wr_trig = wr_go & hit(paddr_i, `DCR_OFF_INT_TRIG);
  wire wr_err = wr_go & hit(paddr_i, `DCR_OFF_ERR_STAT);
  wire wr_evt_mask = wr_go & hit(paddr_i, `DCR_OFF_EVT_MASK);
  wire rd_evt = rd_go & hit(paddr_i, `DCR_OFF_EVT_STAT);
  wire mapped = hit(paddr_i, `DCR_OFF_MOD_CTRL) | hit(paddr_i, `DCR_OFF_EN_SET)
      | hit(paddr_i, `DCR_OFF_EN_CLR) | hit(paddr_i, `DCR_OFF_CH_SEL)
      | hit(paddr_i, `DCR_OFF_ATTR_SET) | hit(paddr_i, `DCR_OFF_ATTR_CLR)
      | hit(paddr_i, `DCR_OFF_SRC_MAP) | hit(paddr_i, `DCR_OFF_MODE)
      | hit(paddr_i, `DCR_OFF_SW_REQ) | hit(paddr_i, `DCR_OFF_DONE_STAT)
      | hit(paddr_i, `DCR_OFF_DONE_CLR) | hit(paddr_i, `DCR_OFF_ROUTE)
      | hit(paddr_i, `DCR_OFF_INT_TRIG) | hit(paddr_i, `DCR_OFF_ERR_STAT)
      | hit(paddr_i, `DCR_OFF_EVT_STAT) | hit(paddr_i, `DCR_OFF_EVT_MASK);
  wire [NUM_CH-1:0] wmask = pwdata_i[NUM_CH-1:0];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic mod_en_ff;
  logic [NUM_CH-1:0] ch_en_ff;
  logic [NUM_CH-1:0] sw_pend_ff;
  logic [NUM_CH-1:0] done_stat_ff;
  logic [CH_W-1:0] ch_sel_ff;
  dcr_attr_t attr_ff [NUM_CH];
  logic [SRC_W-1:0] src_ff [NUM_CH];
  logic [`DCR_NUM_ROUTE-1:0][`DCR_RT_W-1:0] rt_ff;
  logic [`DCR_NUM_ROUTE-1:0] rt_irq_ff;
  logic err_ff;
  logic [`DCR_EVT_W-1:0] evt_ff;
  logic [`DCR_EVT_W-1:0] evt_mask_ff;
  logic irq_ff;
  logic master_ff;
  dcr_state_e state_ff;
  logic [CH_W-1:0] cur_ch_ff;
  logic start_ff;
  dcr_attr_t xattr_ff;
  logic [`DCR_MODE_W-1:0] mode_rd;

  // ----------------------------------------------------------------
  // Per-channel request path
  // ----------------------------------------------------------------
  function automatic logic is_routed(
      input logic [`DCR_NUM_ROUTE-1:0][`DCR_RT_W-1:0] r, input logic [CH_W-1:0] c);
    logic m;
    m = 1'b0;
    for (int k = 0; k < `DCR_NUM_ROUTE; k++) begin
      m = m | (r[k][`DCR_RT_ASG] & (r[k][CH_W-1:0] == c));
    end
    return m;
  endfunction : is_routed

  logic [NUM_CH-1:0] hw_eff;
  logic [NUM_CH-1:0] hi_vec;
  logic [NUM_CH-1:0] done_vec;
  logic [NUM_CH-1:0] routed_vec;
  logic [NUM_CH-1:0] req_vec;
  logic gnt_valid;
  logic [CH_W-1:0] gnt_idx;
  wire busy = (state_ff == ST_BUSY);
  wire done_ev = busy & xfer_done_i;
  wire err_ev = busy & xfer_err_i;
  wire grant = ~busy & mod_en_ff & gnt_valid;

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    dcr_attr_t nxt_attr;
    wire sel = (ch_sel_ff == CH_W'(c));
    wire [SRC_W-1:0] s = src_ff[c];
    // Single requests are dropped for burst-only channels
    wire hw_raw = periph_breq_i[s] | (periph_sreq_i[s] & ~attr_ff[c][`DCR_ATTR_BURST]);
    assign hw_eff[c] = hw_raw & ~attr_ff[c][`DCR_ATTR_MASK];
    assign hi_vec[c] = attr_ff[c][`DCR_ATTR_HI];
    assign done_vec[c] = done_ev & (cur_ch_ff == CH_W'(c));
    assign routed_vec[c] = is_routed(rt_ff, CH_W'(c));
    assign nxt_attr = (attr_ff[c] | ((wr_attr_set & sel) ? pwdata_i[3:0] : 4'h0))
        & ~((wr_attr_clr & sel) ? pwdata_i[3:0] : 4'h0);

    always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
        attr_ff[c] <= '0;
        src_ff[c] <= '0;
      end else begin
        attr_ff[c] <= nxt_attr;
        if (wr_src & sel) begin
          src_ff[c] <= pwdata_i[SRC_W-1:0];
        end
      end
    end
  end

  // Disabled channels raise nothing, hardware or software
  assign req_vec = ch_en_ff & {NUM_CH{mod_en_ff}} & (sw_pend_ff | hw_eff);

  dcr_prio_arb #(.N(NUM_CH), .IW(CH_W)) u_arb (
    .req_i(req_vec),
    .hi_i(hi_vec),
    .gnt_valid_o(gnt_valid),
    .gnt_idx_o(gnt_idx)
  );

  wire [NUM_CH-1:0] gnt_vec = grant ? (NUM_CH'(1) << gnt_idx) : '0;
  // Hardware auto-clear wins over a same-cycle software set
  wire [NUM_CH-1:0] nxt_ch_en = ((ch_en_ff | (wr_en_set ? wmask : '0))
      & ~(wr_en_clr ? wmask : '0)) & ~done_vec;
  wire [NUM_CH-1:0] nxt_sw_pend = (sw_pend_ff | (wr_sw_req ? wmask : '0))
      & ch_en_ff & ~gnt_vec;
  // Clear acts only on master-routed bits; a new completion beats it
  wire [NUM_CH-1:0] nxt_done_stat = (done_stat_ff
      & ~(wr_done_clr ? (wmask & ~routed_vec) : '0)) | (done_vec & ~routed_vec);
  wire nxt_err = err_ev | (err_ff & ~(wr_err & pwdata_i[`DCR_ERR_BIT]));
  wire [`DCR_EVT_W-1:0] evt_set = {err_ev, done_ev};
  wire [`DCR_EVT_W-1:0] nxt_evt = (evt_ff & ~{`DCR_EVT_W{rd_evt}}) | evt_set;

  // ----------------------------------------------------------------
  // Channel control registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mod_en_ff <= 1'b0;
      ch_en_ff <= '0;
      sw_pend_ff <= '0;
      done_stat_ff <= '0;
      ch_sel_ff <= '0;
      rt_ff <= '0;
      err_ff <= 1'b0;
      evt_ff <= '0;
      evt_mask_ff <= '0;
    end else begin
      if (wr_mod) begin
        mod_en_ff <= pwdata_i[`DCR_MOD_EN_BIT];
      end
      ch_en_ff <= nxt_ch_en;
      sw_pend_ff <= nxt_sw_pend;
      done_stat_ff <= nxt_done_stat;
      if (wr_ch_sel) begin
        ch_sel_ff <= pwdata_i[CH_W-1:0];
      end
      if (wr_route) begin
        rt_ff <= pwdata_i[`DCR_NUM_ROUTE*`DCR_RT_W-1:0];
      end
      err_ff <= nxt_err;
      evt_ff <= nxt_evt;
      if (wr_evt_mask) begin
        evt_mask_ff <= pwdata_i[`DCR_EVT_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Transfer sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      cur_ch_ff <= '0;
      start_ff <= 1'b0;
      xattr_ff <= '0;
    end else begin
      start_ff <= grant;
      unique case (state_ff)
        ST_IDLE: begin
          if (grant) begin
            state_ff <= ST_BUSY;
            cur_ch_ff <= gnt_idx;
            xattr_ff <= attr_ff[gnt_idx];
          end
        end
        ST_BUSY: begin
          if (xfer_done_i | xfer_err_i) begin
            state_ff <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // A software mode write colliding with a completion is lost
  wire mem_we = done_ev | wr_mode;
  wire [CH_W-1:0] mem_waddr = done_ev ? cur_ch_ff : ch_sel_ff;
  wire [`DCR_MODE_W-1:0] mem_wdata = done_ev ? `DCR_MODE_IDLE
      : pwdata_i[`DCR_MODE_W-1:0];

  dcr_mode_mem #(.DEPTH(NUM_CH), .AW(CH_W), .DW(`DCR_MODE_W)) u_mode (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .we_i(mem_we),
    .waddr_i(mem_waddr),
    .wdata_i(mem_wdata),
    .raddr_i(ch_sel_ff),
    .rdata_o(mode_rd)
  );

  // ----------------------------------------------------------------
  // Interrupt outputs
  // ----------------------------------------------------------------
  for (genvar k = 0; k < `DCR_NUM_ROUTE; k++) begin : g_rt
    wire own = rt_ff[k][`DCR_RT_ASG] & (rt_ff[k][CH_W-1:0] == cur_ch_ff);
    wire nxt_rt = rt_ff[k][`DCR_RT_EN] & ((done_ev & own) | (wr_trig & pwdata_i[k]));
    always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
        rt_irq_ff[k] <= 1'b0;
      end else begin
        rt_irq_ff[k] <= nxt_rt;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      master_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      master_ff <= |(done_stat_ff & ~routed_vec);
      irq_ff <= |(evt_ff & evt_mask_ff);
    end
  end

  // ----------------------------------------------------------------
  // Read data and bus answer
  // ----------------------------------------------------------------
  wire [31:0] rd_mux =
      ({32{hit(paddr_i, `DCR_OFF_MOD_CTRL)}} & 32'(mod_en_ff))
    | ({32{hit(paddr_i, `DCR_OFF_EN_SET) | hit(paddr_i, `DCR_OFF_EN_CLR)}} & 32'(ch_en_ff))
    | ({32{hit(paddr_i, `DCR_OFF_CH_SEL)}} & 32'(ch_sel_ff))
    | ({32{hit(paddr_i, `DCR_OFF_ATTR_SET) | hit(paddr_i, `DCR_OFF_ATTR_CLR)}}
        & 32'(attr_ff[ch_sel_ff]))
    | ({32{hit(paddr_i, `DCR_OFF_SRC_MAP)}} & 32'(src_ff[ch_sel_ff]))
    | ({32{hit(paddr_i, `DCR_OFF_MODE)}} & 32'(mode_rd))
    | ({32{hit(paddr_i, `DCR_OFF_SW_REQ)}} & 32'(sw_pend_ff))
    | ({32{hit(paddr_i, `DCR_OFF_DONE_STAT)}} & 32'(done_stat_ff & ~routed_vec))
    | ({32{hit(paddr_i, `DCR_OFF_ROUTE)}} & 32'(rt_ff))
    | ({32{hit(paddr_i, `DCR_OFF_ERR_STAT)}} & 32'(err_ff))
    | ({32{hit(paddr_i, `DCR_OFF_EVT_STAT)}} & 32'(evt_ff))
    | ({32{hit(paddr_i, `DCR_OFF_EVT_MASK)}} & 32'(evt_mask_ff));

  // One wait state on every access keeps the memory read registered
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end else begin
      pready_ff <= acc & ~pready_ff;
      pslverr_ff <= acc & ~pready_ff & ~mapped;
      if (rd_load) begin
        prdata_ff <= rd_mux;
      end
    end
  end

  assign prdata_o = prdata_ff;
  assign pready_o = pready_ff;
  assign pslverr_o = pslverr_ff;
  assign xfer_start_o = start_ff;
  assign xfer_ch_o = cur_ch_ff;
  assign xfer_attr_o = xattr_ff;
  assign master_done_irq_o = master_ff;
  assign routed_irq_one_o = rt_irq_ff[0];
  assign routed_irq_two_o = rt_irq_ff[1];
  assign routed_irq_three_o = rt_irq_ff[2];
  assign fault_irq_o = err_ff;
  assign irq_o = irq_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n);

  wire gnt_en = ch_en_ff[gnt_idx];
  wire [NUM_CH-1:0] lower = (NUM_CH'(1) << gnt_idx) - NUM_CH'(1);
  wire [NUM_CH-1:0] klass = hi_vec[gnt_idx] ? hi_vec : {NUM_CH{1'b1}};

  AST_EN_AUTOCLR: assert property (done_ev |=> !ch_en_ff[cur_ch_ff])
    else $error("channel enable not cleared on completion");
  AST_MOD_OFF: assert property (xfer_start_o |-> $past(mod_en_ff))
    else $error("transfer started while module disabled");
  AST_CH_OFF: assert property (grant |=> xfer_start_o && $past(gnt_en))
    else $error("disabled channel was granted");
  AST_HI_FIRST: assert property (grant && |(req_vec & hi_vec) |-> hi_vec[gnt_idx])
    else $error("low class granted over high class");
  AST_LOW_IDX: assert property (grant |-> (req_vec & lower & klass) == '0)
    else $error("lower channel skipped in arbitration");
  AST_ROUTED_MASK: assert property (done_ev && routed_vec[cur_ch_ff] && !done_stat_ff[cur_ch_ff]
      |=> !done_stat_ff[$past(cur_ch_ff)] ##1 !done_stat_ff[$past(cur_ch_ff, 2)])
    else $error("routed channel reached master status");
  AST_DONE_SET: assert property (done_ev && !routed_vec[cur_ch_ff]
      |=> done_stat_ff[cur_ch_ff] ##1 master_done_irq_o || !done_stat_ff[cur_ch_ff])
    else $error("master status or interrupt missed");
  AST_FAULT_HOLD: assert property (fault_irq_o && !wr_err |=> fault_irq_o)
    else $error("error flag dropped without clear");
  AST_TRIG: assert property (wr_trig && pwdata_i[0] && rt_ff[0][`DCR_RT_EN]
      |=> routed_irq_one_o ##1 !routed_irq_one_o || $past(wr_trig))
    else $error("software trigger not delivered");
  AST_MODE_IDLE: assert property (done_ev |-> mem_we && mem_wdata == `DCR_MODE_IDLE)
    else $error("mode not returned to idle");

  COV_START: cover property (grant ##1 xfer_start_o);
  COV_DONE_MASTER: cover property (done_ev ##2 master_done_irq_o);
  COV_DONE_ROUTED: cover property (done_ev && routed_vec[cur_ch_ff] ##1 routed_irq_one_o);
  COV_FAULT: cover property (err_ev ##1 fault_irq_o);
endmodule : dcr_ctrl

// File: sim/dcr_dp_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Data path stand-in: answers each start lat_i + 1 cycles after it is sampled
// ----------------------------------------------------------------
module dcr_dp_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control from the bench
  input wire logic [3:0] lat_i,
  input wire logic err_i,
  // Handshake with the controller
  input wire logic xfer_start_i,
  output logic done_o,
  output logic err_o
);
  logic busy_ff;
  logic [3:0] cnt_ff;

  // Never answers in the start cycle; a lat_i of zero still waits one
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_ff <= 1'b0;
      cnt_ff <= 4'h0;
      done_o <= 1'b0;
      err_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      err_o <= 1'b0;
      if (xfer_start_i) begin
        busy_ff <= 1'b1;
        cnt_ff <= lat_i;
      end else if (busy_ff && cnt_ff == 4'h0) begin
        busy_ff <= 1'b0;
        done_o <= !err_i;
        err_o <= err_i;
      end else if (busy_ff) begin
        cnt_ff <= cnt_ff - 4'h1;
      end
    end
  end
endmodule : dcr_dp_model

// File: sim/dma_channel_control_irq_routing_bench.sv
`timescale 1ns/1ps
`include "dcr_cfg.svh"
module dma_channel_control_irq_routing_bench;
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd_v;
  logic pready, pslverr, err_v;
  logic [7:0] breq = 8'h00, sreq = 8'h00;
  logic start, done, xerr, err_mode = 1'b0;
  logic [4:0] xch;
  logic [3:0] xattr;
  logic mirq, r1, r2, r3, firq, irq;
  int miscompares = 0, n_checks = 0, n_start = 0;
  int n_rt[3] = '{0, 0, 0};
  logic [4:0] last_ch;
  logic [3:0] last_attr;

  always #5 core_clk_i = ~core_clk_i;

  dcr_ctrl dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .periph_breq_i(breq),
    .periph_sreq_i(sreq), .xfer_start_o(start), .xfer_ch_o(xch), .xfer_attr_o(xattr),
    .xfer_done_i(done), .xfer_err_i(xerr), .master_done_irq_o(mirq),
    .routed_irq_one_o(r1), .routed_irq_two_o(r2), .routed_irq_three_o(r3),
    .fault_irq_o(firq), .irq_o(irq));

  dcr_dp_model dp (.clk_i(core_clk_i), .rst_n_i(reset_n_i), .lat_i(4'h3),
    .err_i(err_mode), .xfer_start_i(start), .done_o(done), .err_o(xerr));

  // ----------------------------------------------------------------
  // Pulse monitors
  // ----------------------------------------------------------------
  always @(posedge core_clk_i) begin
    if (start === 1'b1) begin
      n_start++;
      last_ch = xch;
      last_attr = xattr;
    end
    if (r1 === 1'b1) n_rt[0]++;
    if (r2 === 1'b1) n_rt[1]++;
    if (r3 === 1'b1) n_rt[2]++;
  end

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge core_clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk_i);
    penable <= 1'b1;
    // Answer and read data are taken at the edge that samples pready high
    do begin
      @(posedge core_clk_i);
      k++;
    end while (pready !== 1'b1 && k < 20);
    chk("pready", pready, 32'h1);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, rd_v, exp);
  endtask : rdchk

  task automatic wait_start(input int n);
    int k;
    for (k = 0; k < 50 && n_start < n; k++) @(posedge core_clk_i);
    chk("starts", n_start, n);
  endtask : wait_start

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  initial begin
    repeat (20000) @(posedge core_clk_i);
    miscompares++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    rdchk("mod_ctrl", `DCR_OFF_MOD_CTRL, 32'h0);
    apb(1'b0, 8'hfc, 32'h0);
    chk("unmapped err", err_v, 32'h1);
    wr(`DCR_OFF_EVT_MASK, 32'h1);
    wr(`DCR_OFF_EN_SET, 32'h1);
    wr(`DCR_OFF_SW_REQ, 32'h1);
    repeat (10) @(posedge core_clk_i);
    chk("start while off", n_start, 0);
    wr(`DCR_OFF_MODE, 32'h5);
    rdchk("mode set", `DCR_OFF_MODE, 32'h5);
    wr(`DCR_OFF_MOD_CTRL, 32'h1);
    wait_start(1);
    chk("sw channel", last_ch, 0);
    repeat (10) @(posedge core_clk_i);
    rdchk("enable after done", `DCR_OFF_EN_SET, 32'h0);
    rdchk("done stat", `DCR_OFF_DONE_STAT, 32'h1);
    chk("master irq", mirq, 1);
    chk("irq", irq, 1);
    wr(`DCR_OFF_CH_SEL, 32'h0);
    rdchk("mode", `DCR_OFF_MODE, `DCR_MODE_IDLE);
    rdchk("evt stat", `DCR_OFF_EVT_STAT, 32'h1);
    wr(`DCR_OFF_DONE_CLR, 32'h1);
    rdchk("done cleared", `DCR_OFF_DONE_STAT, 32'h0);
    chk("master irq low", mirq, 0);
    chk("irq low", irq, 0);
    // Disabled channel
    wr(`DCR_OFF_EN_SET, 32'h2);
    wr(`DCR_OFF_EN_CLR, 32'h2);
    rdchk("enable cleared", `DCR_OFF_EN_CLR, 32'h0);
    wr(`DCR_OFF_SW_REQ, 32'h2);
    repeat (10) @(posedge core_clk_i);
    chk("start disabled", n_start, 1);
    rdchk("pending disabled", `DCR_OFF_SW_REQ, 32'h0);
    // Attributes one at a time
    wr(`DCR_OFF_CH_SEL, 32'h2);
    for (int i = 0; i < 4; i++) begin
      wr(`DCR_OFF_ATTR_SET, 32'h1 << i);
      rdchk("attr set", `DCR_OFF_ATTR_SET, (32'h2 << i) - 32'h1);
    end
    wr(`DCR_OFF_ATTR_CLR, 32'h5);
    rdchk("attr clr", `DCR_OFF_ATTR_CLR, 32'ha);
    wr(`DCR_OFF_ATTR_CLR, 32'hd);
    // Source map, burst-only, alternate
    wr(`DCR_OFF_SRC_MAP, 32'h5);
    wr(`DCR_OFF_ATTR_SET, 32'h1);
    wr(`DCR_OFF_EN_SET, 32'h4);
    sreq <= 8'h20;
    repeat (10) @(posedge core_clk_i);
    chk("single on burst-only", n_start, 1);
    sreq <= 8'h00;
    breq <= 8'h20;
    wait_start(2);
    breq <= 8'h00;
    chk("mapped channel", last_ch, 2);
    chk("attrs at grant", last_attr, 4'h3);
    repeat (10) @(posedge core_clk_i);
    // Hardware mask keeps software path
    wr(`DCR_OFF_ATTR_SET, 32'h8);
    wr(`DCR_OFF_EN_SET, 32'h4);
    breq <= 8'h20;
    repeat (10) @(posedge core_clk_i);
    chk("masked hw", n_start, 2);
    wr(`DCR_OFF_SW_REQ, 32'h4);
    wait_start(3);
    breq <= 8'h00;
    repeat (10) @(posedge core_clk_i);
    // High class beats lower index
    wr(`DCR_OFF_EN_SET, 32'h38);
    wr(`DCR_OFF_CH_SEL, 32'h4);
    wr(`DCR_OFF_ATTR_SET, 32'h4);
    wr(`DCR_OFF_SW_REQ, 32'h38);
    wait_start(4);
    chk("high first", last_ch, 4);
    wait_start(5);
    chk("then low", last_ch, 3);
    wait_start(6);
    chk("last low", last_ch, 5);
    repeat (10) @(posedge core_clk_i);
    // Routed interrupts
    wr(`DCR_OFF_DONE_CLR, 32'hffffffff);
    wr(`DCR_OFF_ROUTE, 32'h00c8c7c6);
    wr(`DCR_OFF_INT_TRIG, 32'h7);
    repeat (3) @(posedge core_clk_i);
    for (int i = 0; i < 3; i++) chk("routed trig", n_rt[i], 1);
    wr(`DCR_OFF_EN_SET, 32'h40);
    wr(`DCR_OFF_SW_REQ, 32'h40);
    wait_start(7);
    repeat (10) @(posedge core_clk_i);
    chk("routed done", n_rt[0], 2);
    rdchk("routed masked", `DCR_OFF_DONE_STAT, 32'h0);
    chk("master quiet", mirq, 0);
    // Error flag is sticky
    err_mode <= 1'b1;
    wr(`DCR_OFF_EN_SET, 32'h1);
    wr(`DCR_OFF_SW_REQ, 32'h1);
    wait_start(8);
    repeat (30) @(posedge core_clk_i);
    chk("fault held", firq, 1);
    rdchk("err stat", `DCR_OFF_ERR_STAT, 32'h1);
    wr(`DCR_OFF_ERR_STAT, 32'h1);
    repeat (3) @(posedge core_clk_i);
    chk("fault cleared", firq, 0);
    give_verdict();
  end
endmodule : dma_channel_control_irq_routing_bench
